// ==== gsl_consts.vh ====
// Constants for the GPIO and status LED pin block.
`ifndef GSL_CONSTS_VH
`define GSL_CONSTS_VH
`define GSL_NUM_PINS        3
`define GSL_PIN_SPEED       0
`define GSL_PIN_LINK        1
`define GSL_PIN_DUPLEX      2
`define GSL_DIR_INPUT       2'h0
`define GSL_DIR_PUSHPULL    2'h1
`define GSL_DIR_OPENDRAIN   2'h2
`define GSL_CLK_HZ          125000000
`define GSL_BLINK_MS        80
// 80 ms at 125 MHz, sized to the interval counter.
`define GSL_BLINK_CYCLES    24'h98_9680
`define GSL_CNT_W           24
`endif

// ==== gsl_pin_sync.v ====
// Two-flop synchroniser for one pin input.
`timescale 1ns/1ps
`default_nettype none
module gsl_pin_sync (
   input  wire clk,
   input  wire rst_n,
   input  wire din,
   output reg  dout
);
   reg meta_reg;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= 1'b0;
         dout     <= 1'b0;
      end else begin
         meta_reg <= din;
         dout     <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ==== gsl_top.v ====
// GPIO pins multiplexed with speed, link/activity and duplex status LEDs.
`timescale 1ns/1ps
`default_nettype none
`include "gsl_consts.vh"
module gsl_top #(
   parameter [`GSL_CNT_W-1:0] BLINK_CYCLES = `GSL_BLINK_CYCLES
) (
   input  wire       clk,
   input  wire       rst_n,
   input  wire [5:0] gpio_dir_cfg,
   input  wire [2:0] led_sel_cfg,
   input  wire [2:0] gpio_out_val,
   output reg  [2:0] gpio_in_val,
   input  wire       link_up,
   input  wire       link_100m,
   input  wire       link_full_duplex,
   input  wire       link_activity,
   input  wire [2:0] pin_in,
   output reg  [2:0] pin_out,
   output reg  [2:0] pin_oe
);
   // Blink phases. ST_HOLD keeps the LED lit for the minimum on time even while
   // activity never stops, so a busy link still shows a visible blink.
   localparam ST_ON    = 2'h0;
   localparam ST_OFF   = 2'h1;
   localparam ST_HOLD  = 2'h2;

   reg  [1:0]            dir_reg [0:2];
   reg  [2:0]            led_sel_reg;
   reg  [2:0]            out_val_reg;
   reg  [1:0]            blink_reg;
   reg  [1:0]            blink_next;
   reg  [`GSL_CNT_W-1:0] cnt_reg;
   reg  [`GSL_CNT_W-1:0] cnt_next;
   reg  [2:0]            led_level;
   reg  [2:0]            out_next;
   reg  [2:0]            oe_next;
   wire [2:0]            pin_sync;
   wire [2:0]            dir_pushpull;
   wire [2:0]            dir_opendrain;
   wire                  cnt_zero;
   wire                  blink_dark;
   wire                  activity_seen;
   integer               i;

   // Config reaches the pins two edges after it changes, link status inputs one edge, link_activity two.

   genvar g;
   generate
      for (g = 0; g < `GSL_NUM_PINS; g = g + 1) begin : g_sync
         gsl_pin_sync u_sync (
            .clk   (clk),
            .rst_n (rst_n),
            .din   (pin_in[g]),
            .dout  (pin_sync[g])
         );

         // Code 3 is not a drive mode and falls back to input.
         assign dir_pushpull[g]  = (dir_reg[g] == `GSL_DIR_PUSHPULL);
         assign dir_opendrain[g] = (dir_reg[g] == `GSL_DIR_OPENDRAIN);
      end
   endgenerate

   // One counter serves both phases; at this clock 24 bits cap an interval near 134 ms.
   assign cnt_zero      = (cnt_reg == {`GSL_CNT_W{1'b0}});
   assign blink_dark    = (blink_reg == ST_OFF);
   assign activity_seen = link_up & link_activity;

   // Configuration is registered so pin drive changes on a clean edge.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dir_reg[0]  <= `GSL_DIR_INPUT;
         dir_reg[1]  <= `GSL_DIR_INPUT;
         dir_reg[2]  <= `GSL_DIR_INPUT;
         led_sel_reg <= 3'h0;
         out_val_reg <= 3'h0;
      end else begin
         dir_reg[0]  <= gpio_dir_cfg[1:0];
         dir_reg[1]  <= gpio_dir_cfg[3:2];
         dir_reg[2]  <= gpio_dir_cfg[5:4];
         led_sel_reg <= led_sel_cfg;
         out_val_reg <= gpio_out_val;
      end
   end

   // Blink sequencer: off for one interval, then a forced on interval.
   always @* begin
      blink_next = blink_reg;
      cnt_next   = cnt_reg;
      case (blink_reg)
         ST_ON: begin
            if (activity_seen) begin
               blink_next = ST_OFF;
               cnt_next   = BLINK_CYCLES - 1'b1;
            end
         end
         ST_OFF: begin
            if (cnt_zero) begin
               blink_next = ST_HOLD;
               cnt_next   = BLINK_CYCLES - 1'b1;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         ST_HOLD: begin
            if (cnt_zero) begin
               blink_next = ST_ON;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         default: begin
            blink_next = ST_ON;
            cnt_next   = {`GSL_CNT_W{1'b0}};
         end
      endcase
      // Losing the link ends any blink at once.
      if (!link_up) begin
         blink_next = ST_ON;
         cnt_next   = {`GSL_CNT_W{1'b0}};
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         blink_reg <= ST_ON;
      end else begin
         blink_reg <= blink_next;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= {`GSL_CNT_W{1'b0}};
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   always @* begin
      // LED levels are active low. Without a link every LED stays dark.
      led_level = 3'h7;
      if (link_up) begin
         if (link_100m) begin
            led_level[`GSL_PIN_SPEED] = 1'b0;
         end else begin
            led_level[`GSL_PIN_SPEED] = 1'b1;
         end
         if (blink_dark) begin
            led_level[`GSL_PIN_LINK] = 1'b1;
         end else begin
            led_level[`GSL_PIN_LINK] = 1'b0;
         end
         if (link_full_duplex) begin
            led_level[`GSL_PIN_DUPLEX] = 1'b0;
         end else begin
            led_level[`GSL_PIN_DUPLEX] = 1'b1;
         end
      end
   end

   // Pin mux. LED mode overrides the drive mode chosen for general-purpose use.
   always @* begin
      out_next = 3'h0;
      oe_next  = 3'h0;
      for (i = 0; i < `GSL_NUM_PINS; i = i + 1) begin
         if (led_sel_reg[i]) begin
            // LED pins only sink current; a high level releases the pin.
            out_next[i] = 1'b0;
            oe_next[i]  = ~led_level[i];
         end else if (dir_pushpull[i]) begin
            out_next[i] = out_val_reg[i];
            oe_next[i]  = 1'b1;
         end else if (dir_opendrain[i]) begin
            // A 0 pulls the pin low; a 1 lets the board pull it up.
            out_next[i] = 1'b0;
            oe_next[i]  = ~out_val_reg[i];
         end else begin
            out_next[i] = 1'b0;
            oe_next[i]  = 1'b0;
         end
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_out <= 3'h0;
         pin_oe  <= 3'h0;
      end else begin
         pin_out <= out_next;
         pin_oe  <= oe_next;
      end
   end

   // Read back lags the pin by three edges: two in the synchroniser, one here.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gpio_in_val <= 3'h0;
      end else begin
         gpio_in_val <= pin_sync;
      end
   end
endmodule
`default_nettype wire

// ==== gsl_top_asserts.sv ====
// Checker for the pin and LED outputs of gsl_top.
`timescale 1ns/1ps
`default_nettype none
module gsl_chk #(parameter [23:0] BLINK_CYCLES = 24'h00_0008) (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic [5:0] gpio_dir_cfg,
   input wire logic [2:0] led_sel_cfg,
   input wire logic [2:0] gpio_out_val,
   input wire logic       link_up,
   input wire logic       link_100m,
   input wire logic       link_full_duplex,
   input wire logic [2:0] pin_out,
   input wire logic [2:0] pin_oe
);
   // Judge only after the inputs held three edges, past every output latency.
   logic [44:0] h_reg;
   logic [23:0] run_reg;
   logic        oe_reg;
   logic        blk_reg;
   wire  [14:0] v = {gpio_dir_cfg, led_sel_cfg, gpio_out_val,
                     link_up, link_100m, link_full_duplex};
   wire         st = {3{v}} == h_reg;
   wire  [2:0]  ls = led_sel_cfg & {3{st}};
   wire  [2:0]  gs = ~led_sel_cfg & {3{st}};
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {h_reg, run_reg, oe_reg, blk_reg} <= '0;
      end else begin
         h_reg <= {h_reg[29:0], v};
         oe_reg <= pin_oe[1];
         run_reg <= (pin_oe[1] != oe_reg) ? 24'h00_0001 : run_reg + 24'h00_0001;
         blk_reg <= link_up && led_sel_cfg[1] && (blk_reg || (ls[1] && pin_oe[1] && !oe_reg));
      end
   end
   sequence blink_end;
      ls[1] && link_up && pin_oe[1] && !oe_reg;
   endsequence
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_SPEED: assert property (ls[0] |-> pin_oe[0] == (link_up && link_100m))
      else $error("speed led wrong");
   AST_DUPLEX: assert property (ls[2] |-> pin_oe[2] == (link_up && link_full_duplex))
      else $error("duplex led wrong");
   AST_LED_OD: assert property (|ls |-> !(|(pin_oe & pin_out & ls)))
      else $error("led pin driven high");
   AST_LINK_OFF: assert property (ls[1] && !link_up |-> !pin_oe[1])
      else $error("link led lit without link");
   AST_PUSH_PULL: assert property (
      gs[0] && gpio_dir_cfg[1:0] == 2'h1 |-> pin_oe[0] && pin_out[0] == gpio_out_val[0])
      else $error("push-pull pin wrong");
   AST_OPEN_DRAIN: assert property (
      gs[1] && gpio_dir_cfg[3:2] == 2'h2 |-> pin_oe[1] != gpio_out_val[1] && !pin_out[1])
      else $error("open-drain pin wrong");
   AST_INPUT: assert property (gs[2] && gpio_dir_cfg[5:4] == 2'h0 |-> !pin_oe[2])
      else $error("input pin driven");
   AST_BLINK_LEN: assert property (blink_end |-> run_reg == BLINK_CYCLES)
      else $error("blink length wrong");
   AST_HOLD_MIN: assert property (
      ls[1] && blk_reg && oe_reg && !pin_oe[1] |-> run_reg >= BLINK_CYCLES)
      else $error("hold too short");
endmodule
bind gsl_top gsl_chk #(.BLINK_CYCLES(BLINK_CYCLES)) chk (
   .clk              (clk),
   .rst_n            (rst_n),
   .gpio_dir_cfg     (gpio_dir_cfg),
   .led_sel_cfg      (led_sel_cfg),
   .gpio_out_val     (gpio_out_val),
   .link_up          (link_up),
   .link_100m        (link_100m),
   .link_full_duplex (link_full_duplex),
   .pin_out          (pin_out),
   .pin_oe           (pin_oe)
);
`default_nettype wire

// ==== gsl_board.sv ====
// Board side of the three pins: pull-ups and external drivers.
`timescale 1ns/1ps
`default_nettype none
module gsl_board (
   input  wire logic [2:0] pin_out,
   input  wire logic [2:0] pin_oe,
   input  wire logic [2:0] ext_lvl,
   output wire logic [2:0] pin_in
);
   // A released pin shows the board level, the pull-up unless something pulls it low.
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the GPIO and status LED block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       act = 1'b0;
   logic [5:0] dir = 6'h00;
   logic [2:0] sel = 3'h0, gov = 3'h0, ext = 3'h7, lnk = 3'h0, gin, po, oe, pin;
   int         bad_count = 0, checked = 0, n;
   always #4 clk = ~clk;
   gsl_top #(.BLINK_CYCLES(24'h00_0008)) dut (.clk(clk), .rst_n(rst_n), .gpio_dir_cfg(dir),
      .led_sel_cfg(sel), .gpio_out_val(gov), .gpio_in_val(gin), .link_up(lnk[2]),
      .link_100m(lnk[1]), .link_full_duplex(lnk[0]), .link_activity(act), .pin_in(pin),
      .pin_out(po), .pin_oe(oe));
   gsl_board brd (.pin_out(po), .pin_oe(oe), .ext_lvl(ext), .pin_in(pin));
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask
   // Length of the next run of the link LED pin at level lvl, sampled on falling edges.
   task automatic run(input logic lvl, output int len);
      len = 0;
      for (int w = 0; w < 40 && pin[1] !== lvl; w++) @(negedge clk);
      while (pin[1] === lvl && len < 40) begin
         @(negedge clk);
         len++;
      end
   endtask
   task automatic gpio_test;
      dir <= 6'h09;
      gov <= 3'h5;
      ext <= 3'h0;
      cyc(6);
      cmp(gin, 3'h1);
      gov <= 3'h2;
      ext <= 3'h6;
      cyc(6);
      cmp(gin, 3'h6);
   endtask
   task automatic led_test;
      sel <= 3'h7;
      dir <= 6'h15;
      ext <= 3'h7;
      for (int i = 0; i < 8; i++) begin
         lnk <= i[2:0];
         cyc(4);
         cmp(pin, {~(lnk[2] & lnk[0]), ~lnk[2], ~(lnk[2] & lnk[1])});
      end
   endtask
   task automatic blink_test;
      lnk <= 3'h4;
      cyc(4);
      act <= 1'b1;
      run(1'b1, n);
      cmp(n, 8);
      run(1'b0, n);
      cmp(n >= 8, 1);
      @(posedge clk);
      act <= 1'b0;
      cyc(40);
      cmp(pin[1], 0);
      act <= 1'b1;
      cyc(3);
      act <= 1'b0;
      lnk <= 3'h0;
      cyc(4);
      cmp(pin[1], 1);
      lnk <= 3'h4;
      cyc(4);
      cmp(pin[1], 0);
   endtask
   // Mid-run reset: all pins released, read back cleared, LEDs resume after release.
   task automatic reset_test;
      cyc(2);
      rst_n <= 1'b0;
      cyc(3);
      cmp({gin, pin}, 8'h07);
      rst_n <= 1'b1;
      cyc(4);
      cmp(pin, 8'h05);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      cyc(8);
      rst_n <= 1'b1;
      gpio_test();
      led_test();
      blink_test();
      reset_test();
      end_of_test();
   end
   initial begin
      cyc(3000);
      bad_count++;
      end_of_test();
   end
endmodule
`default_nettype wire
